// *** drt_dram_side.sv ***
// far-side model: sequencer pin sources for the clock-enable and low address pins
`timescale 1ns/1ps
module drt_dram_side (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // pin sources
  output logic      o_cke_a,
  output logic      o_cke_b,
  output logic      o_mem_addr_0,
  output logic      o_mem_addr_1
);
  logic [7:0] lfsr_r;
  // ----------------------------------------------------------------
  // pattern source
  // ----------------------------------------------------------------
  // changes every cycle so a stale or swapped pin copy cannot match by luck
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) lfsr_r <= 8'hA5;
    else lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
  end
  // the two enables and the two address bits never share a tap
  assign o_cke_a      = lfsr_r[0];
  assign o_cke_b      = lfsr_r[2];
  assign o_mem_addr_0 = lfsr_r[4];
  assign o_mem_addr_1 = lfsr_r[6];
endmodule

// *** drt_pkg.sv ***
// shared constants and types for the dram row boundary and row type configuration
package drt_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BND0     = 8'h60;
  localparam logic [7:0] IDX_BND5     = 8'h65;
  localparam logic [7:0] IDX_BND3     = 8'h63;
  localparam logic [7:0] IDX_BND4     = 8'h64;
  localparam logic [7:0] IDX_RT_HIGH  = 8'h67;
  localparam int         ADDR_W       = 10;
  localparam int         NROWS        = 6;
  localparam int         BND_W        = 7;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [6:0] BND_RST      = 7'h02;
  localparam logic [6:0] BND_MAX      = 7'h40;  // 256 MB in 4 MB units
  localparam int         FREQ_BIT     = 7;
  localparam int         RT5_HI       = 5;
  localparam int         RT4_HI       = 4;
  localparam int         SEL_BIT      = 2;
  localparam int         RT5_LO       = 1;
  localparam int         RT4_LO       = 0;

  // ----------------------------------------------------------------
  // row type codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RT_PAGE      = 2'h0;
  localparam logic [1:0] RT_EXT_OUT   = 2'h1;
  localparam logic [1:0] RT_SDRAM     = 2'h2;
  localparam logic [1:0] RT_RSVD      = 2'h3;

  typedef logic [BND_W-1:0] drt_bound_t;
  typedef logic [1:0]       drt_code_t;

  // one cycle decision handed to the dram sequencer
  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [5:0] row;
    drt_code_t  code;
  } drt_cyc_s;

endpackage

// *** drt_row_decode.sv ***
// row strobe decode and cycle timing selection for one host access
`timescale 1ns/1ps
module drt_row_decode (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  // configuration
  input  wire drt_pkg::drt_bound_t   i_bound [drt_pkg::NROWS],
  input  wire drt_pkg::drt_code_t    i_code  [drt_pkg::NROWS],
  // access request
  input  wire logic                  i_req,
  input  wire logic [28:22]          i_addr,
  // decision
  output drt_pkg::drt_cyc_s          o_cyc
);

  drt_pkg::drt_cyc_s cyc_nxt;

  // first row whose cumulative limit lies above the address wins;
  // empty rows equal their predecessor and so never match
  always_comb begin
    cyc_nxt       = '0;
    cyc_nxt.valid = i_req;
    for (int i = 0; i < drt_pkg::NROWS; i++) begin
      if (!cyc_nxt.hit && (i_addr < i_bound[i]) && (i_addr < drt_pkg::BND_MAX)) begin
        cyc_nxt.hit    = 1'b1;
        cyc_nxt.row[i] = 1'b1;
        cyc_nxt.code   = i_code[i];
      end
    end
  end

  // decision registered so the sequencer sees a stable timing choice
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cyc <= '0;
    end else begin
      o_cyc <= cyc_nxt;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  one_row_a: assert property (o_cyc.hit |-> $onehot(o_cyc.row))
    else $error("more than one row strobe selected");
  cap_limit_a: assert property (i_req && i_addr >= drt_pkg::BND_MAX |=> !o_cyc.hit)
    else $error("access above 256 MB hit a row");
  row0_type_a: assert property (i_req && i_addr < i_bound[0] && i_addr < drt_pkg::BND_MAX
                                |=> o_cyc.row[0] && o_cyc.code == $past(i_code[0]))
    else $error("row 0 access did not take row 0 timing");

endmodule

// *** drt_row_type_cfg.sv ***
// row boundary and high row type configuration with avalon-mm register access
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module drt_row_type_cfg (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_nrst,
  // avalon-mm slave
  input  wire logic [9:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output logic [31:0]             o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // strap pin and host access
  input  wire logic               i_host_a27_pin,
  input  wire logic               i_cyc_req,
  input  wire logic [28:22]       i_host_addr,
  // pin sources from the dram sequencer
  input  wire logic               i_cke_a,
  input  wire logic               i_cke_b,
  input  wire logic               i_mem_addr_0,
  input  wire logic               i_mem_addr_1,
  // outputs
  output drt_pkg::drt_cyc_s       o_cyc,
  output logic                    o_clock_enable_pin_a,
  output logic                    o_clock_enable_pin_b,
  output logic [6:0]              o_top_of_mem,
  output logic                    o_host_freq_indicator
);

  // ----------------------------------------------------------------
  // reset and strap synchronisers
  // ----------------------------------------------------------------
  logic               rst_meta_r;
  logic               rst_n_r;
  logic               a27_meta_r;
  logic               a27_sync_r;

  // release is synchronised; assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // strap chain runs on the raw reset so it is settled at release
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      a27_meta_r <= 1'b0;
      a27_sync_r <= 1'b0;
    end else begin
      a27_meta_r <= i_host_a27_pin;
      a27_sync_r <= a27_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm handshake
  // ----------------------------------------------------------------
  logic               wait_r;
  logic               wr_go;
  logic [7:0]         idx;

  function automatic logic sel_idx(input logic [9:0] a, input logic [7:0] want);
    sel_idx = (a[1:0] == 2'h0) && (a[9:2] == want);
  endfunction

  assign idx   = i_avs_address[9:2];
  assign wr_go = i_avs_write && !wait_r && i_avs_byteenable[0];

  // one wait cycle per request; the answer edge is where the master samples low
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((i_avs_read || i_avs_write) && wait_r);
    end
  end

  assign o_avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // row boundary registers
  // ----------------------------------------------------------------
  drt_pkg::drt_bound_t bound_r [drt_pkg::NROWS];

  // a row 3 or row 4 write also fills the rows above it, so program upward
  generate
    for (genvar g = 0; g < drt_pkg::NROWS; g++) begin : g_bound
      always_ff @(posedge i_mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          bound_r[g] <= drt_pkg::BND_RST;
        end else if (wr_go && (sel_idx(i_avs_address, drt_pkg::IDX_BND0 + 8'(g)) ||
                     (g > 3 && sel_idx(i_avs_address, drt_pkg::IDX_BND3)) ||
                     (g > 4 && sel_idx(i_avs_address, drt_pkg::IDX_BND4)))) begin
          bound_r[g] <= i_avs_writedata[6:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // row type high register
  // ----------------------------------------------------------------
  logic               freq_r;
  logic               strap_done_r;
  logic               sel_r;
  drt_pkg::drt_code_t code4_r;
  drt_pkg::drt_code_t code5_r;
  logic               rth_wr;

  assign rth_wr = wr_go && sel_idx(i_avs_address, drt_pkg::IDX_RT_HIGH);

  // strap is caught in the first cycle after release, later writes win
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      freq_r       <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      freq_r       <= !a27_sync_r;
      strap_done_r <= 1'b1;
    end else if (rth_wr) begin
      freq_r       <= i_avs_writedata[drt_pkg::FREQ_BIT];
    end
  end

  // row codes and pin select; bits 6 and 3 are not stored
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_r   <= 1'b0;
      code4_r <= drt_pkg::RT_PAGE;
      code5_r <= drt_pkg::RT_PAGE;
    end else if (rth_wr) begin
      sel_r   <= i_avs_writedata[drt_pkg::SEL_BIT];
      code5_r <= {i_avs_writedata[drt_pkg::RT5_HI], i_avs_writedata[drt_pkg::RT5_LO]};
      code4_r <= {i_avs_writedata[drt_pkg::RT4_HI], i_avs_writedata[drt_pkg::RT4_LO]};
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0]         rd_byte;

  // unmapped and misaligned reads return zero
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < drt_pkg::NROWS; i++) begin
      if (sel_idx(i_avs_address, drt_pkg::IDX_BND0 + 8'(i))) begin
        rd_byte = {1'b0, bound_r[i]};
      end
    end
    if (sel_idx(i_avs_address, drt_pkg::IDX_RT_HIGH)) begin
      rd_byte[drt_pkg::FREQ_BIT] = freq_r;
      rd_byte[drt_pkg::RT5_HI]  = code5_r[1];
      rd_byte[drt_pkg::RT4_HI]  = code4_r[1];
      rd_byte[drt_pkg::SEL_BIT] = sel_r;
      rd_byte[drt_pkg::RT5_LO]  = code5_r[0];
      rd_byte[drt_pkg::RT4_LO]  = code4_r[0];
    end
  end

  // data is loaded at the edge that drops waitrequest and holds after
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && wait_r) begin
      o_avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // pins, top of memory, frequency flag
  // ----------------------------------------------------------------
  // rows 0 to 3 run page mode timing; their types are held elsewhere
  drt_pkg::drt_code_t code_all [drt_pkg::NROWS];
  assign code_all[0] = drt_pkg::RT_PAGE;
  assign code_all[1] = drt_pkg::RT_PAGE;
  assign code_all[2] = drt_pkg::RT_PAGE;
  assign code_all[3] = drt_pkg::RT_PAGE;
  assign code_all[4] = code4_r;
  assign code_all[5] = code5_r;

  // pin mux and clamp registered so outputs come from flip-flops
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_clock_enable_pin_a  <= 1'b0;
      o_clock_enable_pin_b  <= 1'b0;
      o_top_of_mem          <= drt_pkg::BND_RST;
    end else begin
      o_clock_enable_pin_a  <= sel_r ? i_mem_addr_0 : i_cke_a;
      o_clock_enable_pin_b  <= sel_r ? i_mem_addr_1 : i_cke_b;
      o_top_of_mem          <= (bound_r[5] > drt_pkg::BND_MAX) ? drt_pkg::BND_MAX
                                                               : bound_r[5];
    end
  end

  assign o_host_freq_indicator = freq_r;

  drt_row_decode u_dec (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_r),
    .i_bound (bound_r),
    .i_code  (code_all),
    .i_req   (i_cyc_req),
    .i_addr  (i_host_addr),
    .o_cyc   (o_cyc)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n_r);

  sequence rth_write_s;
    !wait_r && i_avs_write && i_avs_byteenable[0] && idx == drt_pkg::IDX_RT_HIGH
      && i_avs_address[1:0] == 2'h0;
  endsequence

  strap_load_a: assert property ($rose(strap_done_r) |-> freq_r == !$past(a27_sync_r))
    else $error("strap not loaded inverted");
  freq_write_a: assert property (strap_done_r ##0 rth_write_s |=>
                                 freq_r == $past(i_avs_writedata[7]))
    else $error("frequency bit write not retained");
  freq_hold_a: assert property (strap_done_r && !rth_wr |=> $stable(freq_r))
    else $error("frequency bit changed without write");
  code_map_a: assert property (rth_write_s |=> code5_r == {$past(i_avs_writedata[5]),
                               $past(i_avs_writedata[1])})
    else $error("row 5 code bits misplaced");
  pin_copy_a: assert property (sel_r ##1 sel_r |-> o_clock_enable_pin_b == $past(i_mem_addr_1))
    else $error("pin b not copying address 1");
  // the release edge still resets the pins, so start only once reset is seen high
  pin_cke_a: assert property (rst_n_r && !sel_r |=> o_clock_enable_pin_a == $past(i_cke_a))
    else $error("pin a not clock enable");
  cascade_a: assert property (wr_go && sel_idx(i_avs_address, drt_pkg::IDX_BND3) |=>
                              bound_r[5] == $past(i_avs_writedata[6:0])
                              && bound_r[4] == bound_r[3])
    else $error("row 3 write did not fill rows 4 and 5");
  rsvd_zero_a: assert property (i_avs_read && wait_r && idx == drt_pkg::IDX_RT_HIGH
                                |=> o_avs_readdata[6] == 1'b0 && o_avs_readdata[3] == 1'b0)
    else $error("reserved bits read nonzero");
  top_clamp_a: assert property (o_top_of_mem <= drt_pkg::BND_MAX)
    else $error("top of memory beyond 256 MB");
  wait_one_a: assert property ((i_avs_read || i_avs_write) && wait_r |=> !wait_r ##1 wait_r)
    else $error("waitrequest not a single cycle low");

endmodule

// *** tb_dram_row_type_config.sv ***
// self-checking testbench for the row boundary and row type configuration
`timescale 1ns/1ps
module tb_dram_row_type_config;
  logic i_mclk = 1'b0, i_nrst = 1'b0, rd = 1'b0, wr = 1'b0, a27 = 1'b0, req = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wd   = 32'h0;
  logic [6:0]  haddr = 7'h00;
  logic [31:0] rdata;
  logic        wreq, cka, ckb, ma0, ma1, pa, pb, hfi;
  logic [3:0]  src_q;
  logic [6:0]  tom;
  drt_pkg::drt_cyc_s cyc;
  int err_count = 0, checks_done = 0;
  int m_b [6];
  logic [7:0] m_rt, q;
  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  always #10 i_mclk = ~i_mclk;
  drt_row_type_cfg i_drt_row_type_cfg (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_host_a27_pin(a27), .i_cyc_req(req), .i_host_addr(haddr), .i_cke_a(cka),
    .i_cke_b(ckb), .i_mem_addr_0(ma0), .i_mem_addr_1(ma1), .o_cyc(cyc),
    .o_clock_enable_pin_a(pa), .o_clock_enable_pin_b(pb), .o_top_of_mem(tom),
    .o_host_freq_indicator(hfi));
  drt_dram_side i_drt_dram_side (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_cke_a(cka),
    .o_cke_b(ckb), .o_mem_addr_0(ma0), .o_mem_addr_1(ma1));
  // sources as the design samples them, captured at the same edge the pins take them
  always @(posedge i_mclk) src_q <= {cka, ckb, ma0, ma1};
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // one request, held until waitrequest is sampled low at a rising edge
  task automatic bus(input bit w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    addr <= {idx, 2'b00};
    wd <= {$urandom, d} & 32'h0000_00FF | ({$urandom} << 8);
    rd <= !w;
    wr <= w;
    do begin @(posedge i_mclk); n++; end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // register write that also updates the reference copy
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
    if (idx >= 8'h60 && idx <= 8'h65) m_b[idx - 8'h60] = d & 8'h7F;
    if (idx == 8'h63) m_b[4] = d & 8'h7F;
    if (idx == 8'h63 || idx == 8'h64) m_b[5] = d & 8'h7F;
    if (idx == 8'h67) m_rt = d & 8'hB7;
  endtask
  task automatic rreg(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00);
    if (idx >= 8'h60 && idx <= 8'h65) chk(q, m_b[idx - 8'h60]);
    else if (idx == 8'h67) begin
      chk(q, m_rt);
      chk(hfi, m_rt[7]);
    end
    else chk(q, 8'h00);
  endtask
  task automatic do_reset(input logic strap);
    a27 <= strap;
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    m_rt = {~strap, 7'h00};
    foreach (m_b[i]) m_b[i] = 2;
  endtask
  // one decision request; expected row is the lowest with address below its limit
  task automatic decide(input logic [6:0] a);
    logic [9:0] e;
    e = 10'h200;
    for (int i = 5; i >= 0; i--)
      if (a < m_b[i] && a < 7'h40) e = {2'b11, 6'(1 << i),
        i == 5 ? {m_rt[5], m_rt[1]} : i == 4 ? {m_rt[4], m_rt[0]} : 2'h0};
    @(posedge i_mclk);
    req <= 1'b1;
    haddr <= a;
    @(posedge i_mclk);
    req <= 1'b0;
    @(negedge i_mclk);
    chk(cyc, e);
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] b;
    void'($urandom(32'h7ea2bff3));
    do_reset(1'b0);
    for (int i = 8'h60; i <= 8'h67; i++) rreg(8'(i));
    wreg(8'h67, 8'hFF);
    rreg(8'h67);
    wreg(8'h67, 8'h00);
    rreg(8'h67);
    wreg(8'h63, 8'h98);
    for (int i = 8'h63; i <= 8'h65; i++) rreg(8'(i));
    wreg(8'h64, 8'h20);
    rreg(8'h64);
    rreg(8'h65);
    // pins follow the enables with select clear, the address copy with it set
    for (int s = 0; s < 2; s++) begin
      wreg(8'h67, s ? 8'h04 : 8'h00);
      repeat (2) @(posedge i_mclk);
      repeat (16) begin
        @(negedge i_mclk);
        chk({pa, pb}, s ? src_q[1:0] : src_q[3:2]);
      end
    end
    // every code on rows 4 and 5, random cumulative limits, some rows empty
    for (int j = 0; j < 8; j++) begin
      b = 8'h00;
      for (int i = 8'h60; i <= 8'h65; i++) begin
        b = b + 8'($urandom_range(0, 12));
        wreg(8'(i), b);
      end
      wreg(8'h67, {1'($urandom), 1'($urandom), j[1:0], 1'($urandom), 1'($urandom),
        j[2:1]});
      repeat (2) @(posedge i_mclk);
      chk(tom, m_b[5] > 8'h40 ? 8'h40 : m_b[5]);
      for (int k = 0; k < 10; k++) decide(7'($urandom_range(0, 8'h4A)));
    end
    // strap high gives the low frequency setting
    do_reset(1'b1);
    rreg(8'h67);
    stop_test();
  end
  // watchdog: the whole run takes a few hundred cycles
  initial begin
    #400_000;
    err_count++;
    stop_test();
  end
endmodule
